// ### flash_pkg.sv
// Purpose: shared constants and carriers for the flash pin control block
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes:   pin samples and internal requests travel as packed structs
package flash_pkg;
   localparam int          data_w          = 16;
   localparam int          addr_w          = 24;
   localparam int          blk_w           = 8;
   localparam int          blocks          = 256;
   localparam int          fifo_depth      = 8;
   localparam logic [15:0] status_reset    = 16'h0080;
   localparam logic [15:0] rcr_reset       = 16'h0000;
   localparam int          rcr_wait_pol    = 10;
   localparam int          blk_lsb         = 16;
   // command codes seen at the command interface
   localparam logic [7:0]  cmd_read_array  = 8'hff;
   localparam logic [7:0]  cmd_lock_setup  = 8'h60;
   localparam logic [7:0]  cmd_lock        = 8'h01;
   localparam logic [7:0]  cmd_unlock      = 8'hd0;
   localparam logic [7:0]  cmd_lockdown    = 8'h2f;
   localparam logic [7:0]  cmd_program     = 8'h40;
   localparam logic [7:0]  cmd_rcr_setup   = 8'h60;
   localparam logic [7:0]  cmd_rcr_confirm = 8'h03;
   localparam logic [7:0]  cmd_read_status = 8'h70;
   localparam logic [7:0]  cmd_sync_read   = 8'h0c;

   typedef struct packed {
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
      logic                wp_n;
      logic                adv_n;
      logic                clk_pin;
      logic                program_lockout_level;
      logic                core_lockout_level;
      logic [addr_w-1:0]   addr;
      logic [data_w-1:0]   dq;
   } pins_t;

   typedef struct packed {
      logic [addr_w-1:0]   addr;
      logic [data_w-1:0]   data;
   } wr_word_t;

   typedef enum logic [4:0] {
      st_async  = 5'h01,
      st_status = 5'h02,
      st_sync   = 5'h04,
      st_lock   = 5'h08,
      st_prog   = 5'h10
   } mode_t;
endpackage : flash_pkg

// ### word_fifo.sv
// Purpose: small synchronous FIFO for latched write words
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; pointers carry an extra wrap bit
`timescale 1ns/1ps
module word_fifo #(
   parameter int width = 40,
   parameter int depth = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [width-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw:0]      wr_q;
   logic [aw:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_q ^ rd_q) != {1'b1, {aw{1'b0}}};
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[aw-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
      if (push) begin
         mem[wr_q[aw-1:0]] <= in_data;
      end
   end
endmodule : word_fifo

// ### nor_flash_pin_control.sv
// Purpose: pin-level control of a parallel NOR flash behind its pins
// Assumes: pins are sampled by a 200 MHz clock; reset pin is active low
// Notes:   the array itself sits outside; writes leave through a FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - reset pin clears automation, refuses writes
// - reset exit enters asynchronous array read
// - latch address and data on first rising strobe
// - write protect low enforces block lock-down
// - enforced lock-down ignores unlock for locked-down blocks
// - write protect high bypasses lock-down
// - program supply lockout blocks programs, not lock or config commands
// - core supply lockout rejects array writes
// - host writes on data bus, device drives reads
// - data bus floats when select or enable high
// - config bit 10 sets wait polarity
// - sync burst: wait asserted while data invalid
// - async and write modes hold wait deasserted
// - wait floats unless select and enable low
// - sync address latched on strobe rise or clock
// - deselect enters standby, floats data and wait
// - status reads 0x80 after reset
// - data drivers enabled only while enable low
module nor_flash_pin_control (
   input  wire logic                            clock,
   input  wire logic                            rst,
   input  wire logic                            rst_pin_n,
   input  wire flash_pkg::pins_t                pins,
   output logic      [flash_pkg::data_w-1:0]    dq_out,
   output logic                                 dq_oe,
   output logic                                 wait_out,
   output logic                                 wait_oe,
   output logic                                 standby,
   output logic      [flash_pkg::addr_w-1:0]    read_addr,
   input  wire logic [flash_pkg::data_w-1:0]    array_data,
   input  wire logic                            array_valid,
   output logic                                 wr_valid,
   input  wire logic                            wr_ready,
   output flash_pkg::wr_word_t                  wr_word
);
   typedef struct packed {
      flash_pkg::pins_t                 s1;
      flash_pkg::pins_t                 s2;
      logic                             rstn_s1;
      logic                             rstn_s2;
      logic                             ce_prev;
      logic                             we_prev;
      logic                             adv_prev;
      logic                             clk_prev;
      flash_pkg::mode_t                 mode;
      logic [7:0]                       setup_cmd;
      logic [flash_pkg::data_w-1:0]     status;
      logic [flash_pkg::data_w-1:0]     read_config_reg;
      logic [flash_pkg::blocks-1:0]     locked;
      logic [flash_pkg::blocks-1:0]     lockdown;
      logic [flash_pkg::addr_w-1:0]     addr_lat;
      logic                             addr_held;
      logic                             push;
      flash_pkg::wr_word_t              push_word;
      logic [flash_pkg::data_w-1:0]     dq_out;
      logic                             dq_oe;
      logic                             wait_out;
      logic                             wait_oe;
      logic                             standby;
   } state_t;

   state_t                          q;
   state_t                          d;
   logic                            fifo_ready;
   logic                            fifo_out_valid;
   flash_pkg::wr_word_t             fifo_out;
   logic                            wr_valid_q;
   flash_pkg::wr_word_t             wr_word_q;

   function automatic logic [flash_pkg::blk_w-1:0] blk_of(
      input logic [flash_pkg::addr_w-1:0] a);
      blk_of = a[flash_pkg::blk_lsb +: flash_pkg::blk_w];
   endfunction : blk_of

   // lock-down only holds while write protect is low
   function automatic logic frozen(input state_t s,
                                   input logic [flash_pkg::blk_w-1:0] b);
      frozen = s.lockdown[b] && !s.s2.wp_n;
   endfunction : frozen

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic                          wr_edge;
      logic                          adv_rise;
      logic                          clk_rise;
      logic                          reading;
      logic [flash_pkg::blk_w-1:0]   b;
      logic [7:0]                    c;
      logic                          alter_ok;
      logic                          asserted;
      wr_edge  = 1'b0;
      adv_rise = 1'b0;
      clk_rise = 1'b0;
      reading  = 1'b0;
      b        = '0;
      c        = '0;
      alter_ok = 1'b0;
      asserted = 1'b0;
      d          = q;
      d.push     = 1'b0;
      d.s1       = pins;
      d.s2       = q.s1;
      d.rstn_s1  = rst_pin_n;
      d.rstn_s2  = q.rstn_s1;
      d.ce_prev  = q.s2.ce_n;
      d.we_prev  = q.s2.we_n;
      d.adv_prev = q.s2.adv_n;
      d.clk_prev = q.s2.clk_pin;

      // first rising strobe ends the write; the other one finds it over
      wr_edge  = ((q.s2.we_n && !q.we_prev && !q.ce_prev)
               || (q.s2.ce_n && !q.ce_prev && !q.we_prev))
               && q.s2.oe_n;
      adv_rise = q.s2.adv_n && !q.adv_prev;
      clk_rise = q.s2.clk_pin && !q.clk_prev;
      reading  = !q.s2.ce_n && !q.s2.oe_n && q.s2.we_n;
      b        = blk_of(q.s2.addr);
      c        = q.s2.dq[7:0];
      // both supplies must sit above their lockout levels
      alter_ok = !q.s2.program_lockout_level
               && !q.s2.core_lockout_level;

      if (q.mode == flash_pkg::st_sync) begin
         if (q.s2.adv_n == 1'b0 && !q.addr_held && clk_rise) begin
            d.addr_lat  = q.s2.addr;
            d.addr_held = 1'b1;
         end else if (adv_rise && !q.addr_held) begin
            d.addr_lat  = q.s2.addr;
         end
         if (q.s2.adv_n == 1'b0 && !clk_rise && q.adv_prev) begin
            d.addr_held = 1'b0;
         end
         if (adv_rise) begin
            d.addr_held = 1'b0;
         end
      end else begin
         d.addr_lat  = q.s2.addr;
         d.addr_held = 1'b0;
      end

      if (wr_edge) begin
         d.setup_cmd = '0;
         if (q.setup_cmd == flash_pkg::cmd_lock_setup) begin
            case (c)
               flash_pkg::cmd_lock: begin
                  d.locked[b] = 1'b1;
               end
               flash_pkg::cmd_unlock: begin
                  if (!frozen(q, b)) begin
                     d.locked[b] = 1'b0;
                  end
               end
               flash_pkg::cmd_lockdown: begin
                  d.locked[b]   = 1'b1;
                  d.lockdown[b] = 1'b1;
               end
               flash_pkg::cmd_rcr_confirm: begin
                  d.read_config_reg = q.s2.addr[flash_pkg::data_w-1:0];
               end
               default: begin
               end
            endcase
            d.mode = flash_pkg::st_async;
         end else if (q.setup_cmd == flash_pkg::cmd_program) begin
            // lock bit alone gates programs; lock-down only guards unlock
            if (alter_ok && !q.locked[b] && fifo_ready) begin
               d.push      = 1'b1;
               d.push_word = '{addr: q.s2.addr, data: q.s2.dq};
            end else begin
               d.status[4] = 1'b1;
            end
            d.mode = flash_pkg::st_status;
         end else begin
            case (c)
               flash_pkg::cmd_read_array: d.mode = flash_pkg::st_async;
               flash_pkg::cmd_read_status: d.mode = flash_pkg::st_status;
               flash_pkg::cmd_sync_read: d.mode = flash_pkg::st_sync;
               flash_pkg::cmd_lock_setup: begin
                  d.setup_cmd = c;
                  d.mode      = flash_pkg::st_lock;
               end
               flash_pkg::cmd_program: begin
                  d.setup_cmd = c;
                  d.mode      = flash_pkg::st_prog;
               end
               default: begin
               end
            endcase
         end
      end

      // outputs: data drivers on only while selected, enabled and not writing; wait driver needs select and enable only
      d.standby = q.s2.ce_n;
      d.dq_oe   = reading;
      case (q.mode)
         flash_pkg::st_status: d.dq_out = q.status;
         flash_pkg::st_lock:   d.dq_out = q.read_config_reg;
         default:              d.dq_out = array_data;
      endcase
      d.wait_oe = !q.s2.ce_n && !q.s2.oe_n;
      asserted  = (q.mode == flash_pkg::st_sync) && reading
                  && !array_valid;
      // set bit means wait is high when asserted
      d.wait_out = q.read_config_reg[flash_pkg::rcr_wait_pol]
                   ? asserted : !asserted;

      // reset pin held low: drop automation, float pins
      if (!q.rstn_s2) begin
         d.mode            = flash_pkg::st_async;
         d.setup_cmd       = '0;
         d.push            = 1'b0;
         d.status          = flash_pkg::status_reset;
         d.read_config_reg = flash_pkg::rcr_reset;
         d.locked          = '1;
         d.lockdown        = '0;
         d.dq_oe           = 1'b0;
         d.wait_oe         = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '{s1: '1, s2: '1, rstn_s1: 1'b0, rstn_s2: 1'b0,
                ce_prev: 1'b1, we_prev: 1'b1, adv_prev: 1'b1,
                clk_prev: 1'b1, mode: flash_pkg::st_async,
                setup_cmd: 8'h00, status: flash_pkg::status_reset,
                read_config_reg: flash_pkg::rcr_reset,
                locked: '1, lockdown: '0, addr_lat: '0,
                addr_held: 1'b0, push: 1'b0, push_word: '0,
                dq_out: '0, dq_oe: 1'b0, wait_out: 1'b0,
                wait_oe: 1'b0, standby: 1'b1};
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   word_fifo #(
      .width ($bits(flash_pkg::wr_word_t)),
      .depth (flash_pkg::fifo_depth)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst || !q.rstn_s2),
      .in_valid  (q.push),
      .in_ready  (fifo_ready),
      .in_data   (q.push_word),
      .out_valid (fifo_out_valid),
      .out_ready (wr_ready && !wr_valid_q),
      .out_data  (fifo_out)
   );

   // registered output stage keeps all outputs on flip-flops
   always_ff @(posedge clock) begin
      if (rst || !q.rstn_s2) begin
         wr_valid_q <= 1'b0;
         wr_word_q  <= '0;
      end else if (!wr_valid_q || wr_ready) begin
         wr_valid_q <= fifo_out_valid && wr_ready && !wr_valid_q;
         wr_word_q  <= fifo_out;
      end
   end

   assign dq_out    = q.dq_out;
   assign dq_oe     = q.dq_oe;
   assign wait_out  = q.wait_out;
   assign wait_oe   = q.wait_oe;
   assign standby   = q.standby;
   assign read_addr = q.addr_lat;
   assign wr_valid  = wr_valid_q;
   assign wr_word   = wr_word_q;
endmodule : nor_flash_pin_control

// ### flash_pin_properties.sv
// Purpose: port-level properties of the flash pin control
// Assumes: pins reach the outputs 3 to 4 clocks late
// Notes:   windows of 5 cover the worst pin latency
`timescale 1ns/1ps
module flash_pin_checker (
   input wire logic                clock,
   input wire logic                rst,
   input wire logic                rst_pin_n,
   input wire flash_pkg::pins_t    pins,
   input wire logic                dq_oe,
   input wire logic                wait_oe,
   input wire logic                standby,
   input wire logic                wr_valid,
   input wire logic                wr_ready,
   input wire flash_pkg::wr_word_t wr_word
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence off_s; (pins.ce_n || pins.oe_n) [*5]; endsequence
   sequence desel_s; pins.ce_n [*5]; endsequence
   sequence pin_rst_s; !rst_pin_n [*5]; endsequence
   sequence stall_s; wr_valid && !wr_ready; endsequence
////////////////////////////////////////////////////////////
   data_float_a: assert property (off_s |-> !dq_oe)
      else $error("data bus driven while disabled");
   wait_float_a: assert property (off_s |-> !wait_oe)
      else $error("wait driven while disabled");
   standby_set_a: assert property (desel_s |-> standby)
      else $error("no standby while deselected");
   standby_quiet_a: assert property (standby |-> !dq_oe && !wait_oe)
      else $error("outputs driven in standby");
   pin_reset_a: assert property (pin_rst_s |-> !wr_valid && !dq_oe)
      else $error("activity while reset pin low");
   word_hold_a: assert property (stall_s |=> wr_valid && $stable(wr_word))
      else $error("write word dropped or changed");
   dq_cause_a: assert property (dq_oe |-> !$past(pins.oe_n, 3) || !$past(pins.oe_n, 4))
      else $error("data driven without output enable");
   wait_cause_a: assert property (wait_oe |-> !$past(pins.ce_n, 3) || !$past(pins.ce_n, 4))
      else $error("wait driven without select");
   sync_reset_a: assert property (disable iff (1'b0) rst |=> standby && !wr_valid)
      else $error("outputs not cleared by reset");
endmodule : flash_pin_checker

bind nor_flash_pin_control flash_pin_checker chk (.clock(clock), .rst(rst),
   .rst_pin_n(rst_pin_n), .pins(pins), .dq_oe(dq_oe), .wait_oe(wait_oe),
   .standby(standby), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_word(wr_word));

// ### flash_array_model.sv
// Purpose: array and program sink beside the pin control
// Assumes: same clock as the block
// Notes:   takes a word only every other cycle; with the block's output stage, one word passes every 4 cycles
`timescale 1ns/1ps
module flash_array_model (
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic [flash_pkg::addr_w-1:0] read_addr,
   output logic      [flash_pkg::data_w-1:0] array_data,
   output logic                              array_valid,
   input  wire logic                         wr_valid,
   output logic                              wr_ready,
   input  wire logic                         stall,
   input  wire logic                         starve
);
   logic [3:0] ph_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         ph_q <= 4'h0;
      end else begin
         ph_q <= ph_q + 4'h1;
      end
   end
   assign wr_ready = !stall && ph_q[0] && (wr_valid || !wr_valid);
   // invalid data keeps moving so no stale copy can pass
   assign array_data = starve ? {4{ph_q}} : read_addr[15:0] ^ 16'ha5a5;
   assign array_valid = !starve;
endmodule : flash_array_model

// ### tb_nor_flash_pin_control.sv
// Purpose: self-checking bench for the flash pin control
// Assumes: host pins driven on the falling clock edge
// Notes:   refused programs show as unexpected words
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
   err_count++; $display("BAD %0t value mismatch", $time); end end
module tb_nor_flash_pin_control;
   logic                         clock = 1'b0;
   logic                         rst = 1'b1;
   logic                         rst_pin_n = 1'b0;
   logic                         stall = 1'b0;
   logic                         starve = 1'b0;
   flash_pkg::pins_t             pins;
   logic [flash_pkg::data_w-1:0] dq_out, array_data;
   logic [flash_pkg::addr_w-1:0] read_addr;
   logic                         dq_oe, wait_out, wait_oe, standby;
   logic                         array_valid, wr_valid, wr_ready;
   flash_pkg::wr_word_t          wr_word;
   flash_pkg::wr_word_t          exp_q[$];
   logic [15:0]                  lfsr_q = 16'h0018;
   int                           err_count = 0;
   int                           n_checks = 0;
   int                           cycles = 0;

   nor_flash_pin_control DUT (.clock(clock), .rst(rst),
      .rst_pin_n(rst_pin_n), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
      .wait_out(wait_out), .wait_oe(wait_oe), .standby(standby),
      .read_addr(read_addr), .array_data(array_data),
      .array_valid(array_valid), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_word(wr_word));
   flash_array_model arr (.clock(clock), .rst(rst), .read_addr(read_addr),
      .array_data(array_data), .array_valid(array_valid),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .stall(stall),
      .starve(starve));

   always #2.5 clock = ~clock;
   always @(negedge clock) pins.clk_pin <= ~pins.clk_pin;
////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic end_sim;
      `CHK(exp_q.size(), 0)
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   // random strobe order per cycle
   task automatic cyc(input logic [23:0] a, input logic [15:0] d);
      lfsr_q = lfsr(lfsr_q);
      @(negedge clock);
      {pins.addr, pins.dq, pins.adv_n} = {a, d, 1'b1};
      {pins.ce_n, pins.oe_n, pins.we_n} = 3'h2;
      repeat (3) @(negedge clock);
      if (lfsr_q[0]) pins.ce_n = 1'b1;
      else pins.we_n = 1'b1;
      repeat (3) @(negedge clock);
      {pins.ce_n, pins.we_n, pins.dq} = {2'h3, ~d};
      repeat (2) @(negedge clock);
   endtask : cyc

   task automatic lk(input logic [23:0] a, input logic [7:0] c);
      cyc(a, {8'h00, flash_pkg::cmd_lock_setup});
      cyc(a, {8'h00, c});
   endtask : lk

   task automatic prog(input logic [23:0] a, input logic ok);
      logic [15:0] d;
      lfsr_q = lfsr(lfsr_q);
      d = lfsr_q;
      cyc(a, {8'h00, flash_pkg::cmd_program});
      if (ok) exp_q.push_back({a, d});
      cyc(a, d);
   endtask : prog

   task automatic rd(input logic [23:0] a, input logic [15:0] d,
                     input logic w);
      @(negedge clock);
      {pins.addr, pins.adv_n} = {a, 1'b0};
      {pins.ce_n, pins.oe_n, pins.we_n} = 3'h1;
      repeat (6) @(negedge clock);
      `CHK(dq_oe, 1'b1)
      `CHK(wait_oe, 1'b1)
      `CHK(wait_out, w)
      `CHK(read_addr, a)
      if (!starve) `CHK(dq_out, d)
      {pins.ce_n, pins.oe_n, pins.adv_n} = 3'h7;
      repeat (6) @(negedge clock);
      `CHK(dq_oe, 1'b0)
   endtask : rd

   // words leave through the stalling sink; oldest note first
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         end_sim;
      end
      if (!rst && wr_valid === 1'b1 && wr_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("BAD %0t unexpected word", $time);
         end else `CHK(wr_word, exp_q.pop_front())
      end
   end

   initial begin
      pins = {5'h1d, 3'h0, 24'h000000, 16'h0000};
      repeat (10) @(negedge clock);
      {rst, rst_pin_n} = 2'h1;
      repeat (4) @(negedge clock);
      cyc(24'h000000, {8'h00, flash_pkg::cmd_read_status});
      rd(24'h000000, flash_pkg::status_reset, 1'b1);
      cyc(24'h000000, {8'h00, flash_pkg::cmd_read_array});
      rd(24'h012345, 16'h2345 ^ 16'ha5a5, 1'b1);
      prog(24'h010000, 1'b0);
      lk(24'h010000, flash_pkg::cmd_unlock);
      for (int i = 0; i < 4; i++) prog(24'h010000 + i, 1'b1);
      lk(24'h020000, flash_pkg::cmd_lockdown);
      lk(24'h020000, flash_pkg::cmd_unlock);
      prog(24'h020000, 1'b0);
      pins.wp_n = 1'b1;
      lk(24'h020000, flash_pkg::cmd_unlock);
      prog(24'h020004, 1'b1);
      pins.program_lockout_level = 1'b1;
      prog(24'h010010, 1'b0);
      {pins.program_lockout_level, pins.core_lockout_level} = 2'h1;
      prog(24'h010011, 1'b0);
      pins.core_lockout_level = 1'b0;
      stall = 1'b1;
      // the ninth word finds the FIFO full and must be refused
      for (int i = 0; i < 9; i++) prog(24'h010020 + i, i < 8);
      stall = 1'b0;
      lk(24'h000400, flash_pkg::cmd_rcr_confirm);
      cyc(24'h000000, {8'h00, flash_pkg::cmd_sync_read});
      starve = 1'b1;
      rd(24'h000100, 16'h0000, 1'b1);
      starve = 1'b0;
      rd(24'h000100, 16'h0100 ^ 16'ha5a5, 1'b0);
      rst_pin_n = 1'b0;
      prog(24'h010030, 1'b0);
      rst_pin_n = 1'b1;
      repeat (4) @(negedge clock);
      // starved array shows wait only if sync mode survived the reset
      starve = 1'b1;
      rd(24'h000200, 16'h0200 ^ 16'ha5a5, 1'b1);
      starve = 1'b0;
      repeat (40) @(negedge clock);
      end_sim;
   end
endmodule : tb_nor_flash_pin_control
